//--- pkg/timer_counter_defs.svh
`ifndef TIMER_COUNTER_DEFS_SVH
`define TIMER_COUNTER_DEFS_SVH

// ----------------------------------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------------------------------
`define TC_ADDR_W      12
`define TC_IDX_TIMER   8'h01
`define TC_IDX_INTCTL  8'h0b
`define TC_IDX_OPTION  8'h81
`define TC_IDX_CTRL    8'h90

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TC_OPT_CS      5
`define TC_OPT_SE      4
`define TC_OPT_PSA     3
`define TC_OPT_PS_HI   2
`define TC_OPT_PS_LO   0
`define TC_INT_EN      5
`define TC_INT_FLAG    2
`define TC_CTL_SLEEP   0
`define TC_CTL_WDCLR   1

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define TC_OPT_RST     6'h3f
`define TC_TMR_RST     8'h00
`define TC_TMR_MAX     8'hff
`define TC_PRE_RST     8'h00
`define TC_INHIBIT     2'h2
`define TC_DATA_ZERO   32'h0000_0000

`endif

//--- pkg/timer_counter_pkg.sv
package timer_counter_pkg;

  // Quarter phases of one instruction cycle
  typedef enum logic [1:0] {
    phase_one   = 2'b00,
    phase_two   = 2'b01,
    phase_three = 2'b10,
    phase_four  = 2'b11
  } phase_e;

  typedef logic [7:0] count_t;
  typedef logic [2:0] ratio_t;

endpackage

//--- test/count_source.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Far side: count pulse source and watchdog base clock
// ------------------------------------------------------------
module count_source (
  input  wire logic pclk,
  input  wire logic tick_en,
  output      logic pin,
  output      logic tick
);
  int tc = 0;

  initial begin
    pin = 1'b0;
    tick = 1'b0;
  end

  // Steady base clock, one pulse every third cycle
  always @(posedge pclk) begin
    tc <= (tc + 1) % 3;
    tick <= tick_en && (tc == 0);
  end

  // Each level held h cycles, never under two
  task automatic toggle(input int n, input int h);
    repeat (n) begin
      repeat (h) @(posedge pclk);
      pin <= ~pin;
    end
  endtask
endmodule // count_source

//--- test/tb_timer_counter_with_shared_prescaler.sv
`timescale 1ns/1ps
`include "timer_counter_defs.svh"

module tb_timer_counter_with_shared_prescaler;
  localparam logic [11:0] ad_tmr = {2'b00, `TC_IDX_TIMER, 2'b00};
  localparam logic [11:0] ad_int = {2'b00, `TC_IDX_INTCTL, 2'b00};
  localparam logic [11:0] ad_opt = {2'b00, `TC_IDX_OPTION, 2'b00};
  localparam logic [11:0] ad_ctl = {2'b00, `TC_IDX_CTRL, 2'b00};

  logic                  pclk;
  logic                  presetn;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [`TC_ADDR_W-1:0] paddr;
  logic [31:0]           pwdata;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  pin;
  logic                  tick;
  logic                  tick_en;
  logic                  wd_post;
  logic                  wd_clr;
  logic                  irq;
  logic [31:0]           rd;
  logic [31:0]           v;
  logic                  err;
  logic [7:0]            x;
  int                    n_fail;
  int                    checks;
  int                    edge_n;
  int                    cyc;
  int                    n_post;
  int                    n_clr;
  int                    seed;
  int                    t_wr;
  int                    t_rd;
  int                    w;

  timer_counter_top dut (
    .pclk               (pclk),
    .presetn            (presetn),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .external_count_pin (pin),
    .watchdog_tick      (tick),
    .watchdog_postscale (wd_post),
    .watchdog_clear     (wd_clr),
    .timer_irq          (irq)
  );

  count_source src (
    .pclk    (pclk),
    .tick_en (tick_en),
    .pin     (pin),
    .tick    (tick)
  );

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ------------------------------------------------------------
  // Monitors; edge_n numbers edges since reset release
  // ------------------------------------------------------------
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (presetn) edge_n <= edge_n + 1;
    if (wd_post === 1'b1) n_post <= n_post + 1;
    if (wd_clr === 1'b1) n_clr <= n_clr + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // APB cycle; setup edge waits until edge number 'at'
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input int at);
    @(posedge pclk);
    while (edge_n + 1 < at) @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    t_rd = edge_n;
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    t_wr = edge_n + 1;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 0);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 0);
    chk(rd, e);
  endtask

  // Phase-four edges in (a,b], first two after a write lost
  function automatic logic [31:0] tmr_exp(input logic [7:0] d,
                                         input int a, input int b);
    int k;
    k = b / 4 - a / 4 - 2;
    if (k < 0) k = 0;
    return {24'h0, d + k[7:0]};
  endfunction

  task automatic cnt_case(input logic [31:0] o, input int n,
                          input logic [31:0] e);
    wr(ad_opt, o);
    wr(ad_tmr, 32'h0);
    repeat (12) @(posedge pclk);
    src.toggle(n, 2);
    repeat (16) @(posedge pclk);
    rdc(ad_tmr, e);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 32'he4fb362c;
    {presetn, psel, penable, pwrite, tick_en} = 5'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    {n_fail, checks, edge_n, cyc, n_post, n_clr} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdc(ad_opt, 32'h3f);
    rdc(ad_tmr, 32'h0);
    rdc(ad_int, 32'h0);
    apb(1'b0, 12'h008, 32'h0, 0);
    chk({err, rd[30:0]}, 32'h8000_0000);
    $display("reset and map test done");
    wr(ad_opt, 32'h08);
    for (int i = 0; i < 8; i++) begin
      x = (i == 0) ? 8'hfe : 8'($random(seed));
      wr(ad_tmr, {24'h0, x});
      w = t_wr;
      apb(1'b0, ad_tmr, 32'h0, w + 1 + ($random(seed) & 31));
      chk(rd, tmr_exp(x, w, t_rd));
    end
    $display("timer mode test done");
    for (int n = 0; n < 8; n++) begin
      wr(ad_opt, n);
      wr(ad_tmr, 32'h0);
      apb(1'b0, ad_tmr, 32'h0, t_wr + 20);
      w = t_rd;
      v = rd;
      apb(1'b0, ad_tmr, 32'h0, w + (16 << n));
      chk(rd - v, 32'h2);
    end
    // Writes closer than one prescaled step keep it at zero
    repeat (4) apb(1'b1, ad_tmr, 32'h0, t_wr + 400);
    apb(1'b0, ad_tmr, 32'h0, t_wr + 1000);
    chk(rd, 32'h0);
    $display("prescaler test done");
    cnt_case(32'h28, 9, 32'h5);
    cnt_case(32'h38, 7, 32'h4);
    cnt_case(32'h20, 16, 32'h4);
    $display("counter mode test done");
    wr(ad_opt, 32'h08);
    wr(ad_int, 32'h20);
    wr(ad_tmr, 32'hfd);
    repeat (60) @(posedge pclk);
    rdc(ad_int, 32'h24);
    chk({31'h0, irq}, 32'h1);
    repeat (100) @(posedge pclk);
    rdc(ad_int, 32'h24);
    wr(ad_int, 32'h0);
    wr(ad_tmr, 32'hfd);
    repeat (60) @(posedge pclk);
    rdc(ad_int, 32'h04);
    chk({31'h0, irq}, 32'h0);
    wr(ad_int, 32'h0);
    $display("overflow test done");
    wr(ad_ctl, 32'h1);
    wr(ad_tmr, 32'hff);
    repeat (100) @(posedge pclk);
    rdc(ad_tmr, 32'hff);
    rdc(ad_int, 32'h0);
    rdc(ad_ctl, 32'h1);
    wr(ad_ctl, 32'h0);
    $display("sleep test done");
    tick_en <= 1'b1;
    w = n_post;
    repeat (400) @(posedge pclk);
    chk({31'h0, n_post > w}, 32'h1);
    w = n_clr;
    wr(ad_ctl, 32'h2);
    repeat (4) @(posedge pclk);
    chk(n_clr - w, 32'h1);
    wr(ad_opt, 32'h00);
    repeat (2) @(posedge pclk);
    w = n_post;
    repeat (400) @(posedge pclk);
    chk(n_post - w, 32'h0);
    wr(ad_tmr, 32'h0);
    wr(ad_ctl, 32'h2);
    wr(ad_opt, 32'h08);
    rdc(ad_ctl, 32'h0);
    $display("watchdog sharing test done");
    conclude();
  end
endmodule // tb_timer_counter_with_shared_prescaler

//--- verilog/count_sync.sv
`timescale 1ns/1ps

module count_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic phase_two,
  input  wire logic phase_four,
  input  wire logic level_in,
  output      logic rise
);

  logic q2_q;
  logic q4_q;
  logic q4_prev_q;
  logic strobe;

  // ----------------------------------------------------------------
  // Sample on phase two and on phase four
  // ----------------------------------------------------------------
  // Strobe every other clock, so a two-clock level is never missed
  assign strobe = phase_two || phase_four;

  // Reset high: an input already high after reset gives no false rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q2_q <= 1'b1;
    end else if (strobe) begin
      q2_q <= level_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q4_q <= 1'b1;
    end else if (strobe) begin
      q4_q <= q2_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q4_prev_q <= 1'b1;
    end else begin
      q4_prev_q <= q4_q;
    end
  end

  // Lag of three or four clocks behind the pin edge, set by the strobe phase, never on the edge itself
  assign rise = q4_q && !q4_prev_q;

endmodule // count_sync

//--- verilog/timer_counter_top.sv
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "timer_counter_defs.svh"


module timer_counter_top (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [`TC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output      logic [31:0]           prdata,
  output      logic                  pready,
  output      logic                  pslverr,
  input  wire logic                  external_count_pin,
  input  wire logic                  watchdog_tick,
  output      logic                  watchdog_postscale,
  output      logic                  watchdog_clear,
  output      logic                  timer_irq
);

  timer_counter_pkg::phase_e phase_q;
  timer_counter_pkg::count_t timer_count_q;
  timer_counter_pkg::count_t timer_count_d;
  timer_counter_pkg::count_t presc_count;
  logic [5:0]                option_q;
  logic                      overflow_flag_q;
  logic                      overflow_en_q;
  logic                      sleep_q;
  logic [1:0]                inhibit_q;
  logic                      src_prev_q;
  logic [31:0]               prdata_q;
  logic                      pready_q;
  logic                      pslverr_q;
  logic                      wd_post_q;
  logic                      wd_clear_q;
  logic                      irq_q;

  logic clock_source_select;
  logic source_edge_select;
  logic prescaler_assign;
  logic inst_end;
  logic src_level;
  logic src_rise;
  logic presc_event;
  logic presc_clear;
  logic presc_level;
  logic presc_wrap;
  logic sync_in;
  logic sync_rise;
  logic timer_tick;
  logic timer_inc;
  logic wr_access;
  logic wr_timer;
  logic wr_intctl;
  logic wr_ctrl;
  logic wr_wdclr;
  logic mapped;
  timer_counter_pkg::ratio_t prescale_ratio_select;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic hits(input logic [`TC_ADDR_W-1:0] a,
                                input logic [7:0] idx);
    hits = (a[1:0] == 2'h0) && (a[`TC_ADDR_W-1:10] == 2'h0) &&
           (a[9:2] == idx);
  endfunction

  assign mapped    = hits(paddr, `TC_IDX_TIMER) ||
                     hits(paddr, `TC_IDX_INTCTL) ||
                     hits(paddr, `TC_IDX_OPTION) ||
                     hits(paddr, `TC_IDX_CTRL);
  assign wr_access = psel && penable && pready_q && pwrite;
  assign wr_timer  = wr_access && hits(paddr, `TC_IDX_TIMER);
  assign wr_intctl = wr_access && hits(paddr, `TC_IDX_INTCTL);
  assign wr_ctrl   = wr_access && hits(paddr, `TC_IDX_CTRL);
  assign wr_wdclr  = wr_ctrl && pwdata[`TC_CTL_WDCLR];

  assign clock_source_select   = option_q[`TC_OPT_CS];
  assign source_edge_select    = option_q[`TC_OPT_SE];
  assign prescaler_assign      = option_q[`TC_OPT_PSA];
  assign prescale_ratio_select = option_q[`TC_OPT_PS_HI:`TC_OPT_PS_LO];

  // ----------------------------------------------------------------
  // Quarter phase sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= timer_counter_pkg::phase_one;
    end else begin
      case (phase_q)
        timer_counter_pkg::phase_one:   phase_q <= timer_counter_pkg::phase_two;
        timer_counter_pkg::phase_two:   phase_q <= timer_counter_pkg::phase_three;
        timer_counter_pkg::phase_three: phase_q <= timer_counter_pkg::phase_four;
        timer_counter_pkg::phase_four:  phase_q <= timer_counter_pkg::phase_one;
        default:                        phase_q <= timer_counter_pkg::phase_one;
      endcase
    end
  end

  assign inst_end = (phase_q == timer_counter_pkg::phase_four);

  // ----------------------------------------------------------------
  // Count source and shared prescaler
  // ----------------------------------------------------------------
  // Pin is taken as synchronous, so the edge detect needs no extra stage
  assign src_level = external_count_pin ^ source_edge_select;
  assign src_rise  = src_level && !src_prev_q;

  // Reset high, so a level already high is not taken for an edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prev_q <= 1'b1;
    end else begin
      src_prev_q <= src_level;
    end
  end

  // Routing follows the assign bit live, no stop needed to switch
  assign presc_event = prescaler_assign ? watchdog_tick :
                       (!sleep_q && (clock_source_select ? src_rise
                                                         : inst_end));
  assign presc_clear = prescaler_assign ? wr_wdclr : wr_timer;

  timer_prescaler u_prescaler (
    .pclk      (pclk),
    .presetn   (presetn),
    .count_en  (presc_event),
    .clear     (presc_clear),
    .ratio_sel (prescale_ratio_select),
    .out_level (presc_level),
    .wrap      (presc_wrap),
    .count     (presc_count)
  );

  // Divider sits ahead of the sampler in counter mode while assigned to the timer
  assign sync_in = prescaler_assign ? src_level : presc_level;

  count_sync u_sync (
    .pclk       (pclk),
    .presetn    (presetn),
    .phase_two  (phase_q == timer_counter_pkg::phase_two),
    .phase_four (inst_end),
    .level_in   (sync_in),
    .rise       (sync_rise)
  );

  assign timer_tick = clock_source_select ? sync_rise :
                      (prescaler_assign ? inst_end : presc_wrap);
  assign timer_inc  = timer_tick && !sleep_q && (inhibit_q == 2'h0) &&
                      !wr_timer;

  // ----------------------------------------------------------------
  // Timer register
  // ----------------------------------------------------------------
  always_comb begin
    timer_count_d = timer_count_q;
    if (wr_timer) begin
      timer_count_d = pwdata[7:0];
    end else if (timer_inc) begin
      timer_count_d = timer_count_q + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_count_q <= `TC_TMR_RST;
    end else begin
      timer_count_q <= timer_count_d;
    end
  end

  // Counted in instruction cycles, so a write loses two steps in unprescaled timer mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inhibit_q <= 2'h0;
    end else if (wr_timer) begin
      inhibit_q <= `TC_INHIBIT;
    end else if (inst_end && (inhibit_q != 2'h0)) begin
      inhibit_q <= inhibit_q - 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Option, interrupt control and sleep state
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_q <= `TC_OPT_RST;
    end else if (wr_access && hits(paddr, `TC_IDX_OPTION)) begin
      option_q <= pwdata[5:0];
    end
  end

  // Set beats a clearing write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag_q <= 1'b0;
    end else if (timer_inc && (timer_count_q == `TC_TMR_MAX)) begin
      overflow_flag_q <= 1'b1;
    end else if (wr_intctl) begin
      overflow_flag_q <= pwdata[`TC_INT_FLAG];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_en_q <= 1'b0;
      sleep_q       <= 1'b0;
    end else begin
      if (wr_intctl) begin
        overflow_en_q <= pwdata[`TC_INT_EN];
      end
      if (wr_ctrl) begin
        sleep_q <= pwdata[`TC_CTL_SLEEP];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q      <= 1'b0;
      wd_post_q  <= 1'b0;
      wd_clear_q <= 1'b0;
    end else begin
      irq_q      <= overflow_flag_q && overflow_en_q;
      wd_post_q  <= prescaler_assign && presc_wrap;
      wd_clear_q <= wr_wdclr;
    end
  end

  // ----------------------------------------------------------------
  // APB slave, one wait-free access phase
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= `TC_DATA_ZERO;
    end else begin
      pready_q  <= psel && !penable;
      pslverr_q <= psel && !penable && !mapped;
      prdata_q  <= `TC_DATA_ZERO;
      if (psel && !penable && !pwrite) begin
        // Prescaler count is deliberately absent from the map
        if (hits(paddr, `TC_IDX_TIMER)) begin
          prdata_q <= {24'h000000, timer_count_q};
        end else if (hits(paddr, `TC_IDX_OPTION)) begin
          prdata_q <= {26'h0000000, option_q};
        end else if (hits(paddr, `TC_IDX_INTCTL)) begin
          prdata_q <= {26'h0000000, overflow_en_q, 2'h0,
                       overflow_flag_q, 2'h0};
        end else if (hits(paddr, `TC_IDX_CTRL)) begin
          prdata_q <= {31'h00000000, sleep_q};
        end
      end
    end
  end

  assign prdata             = prdata_q;
  assign pready             = pready_q;
  assign pslverr            = pslverr_q;
  assign watchdog_postscale = wd_post_q;
  assign watchdog_clear     = wd_clear_q;
  assign timer_irq          = irq_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_timer_rate: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!clock_source_select && prescaler_assign && inst_end && !sleep_q &&
     inhibit_q == 2'h0 && !wr_timer)
    |=> timer_count_q == $past(timer_count_q) + 8'h01)
    else $error("timer missed an instruction cycle step");

  a_write_inhibit: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_timer ##1 (!wr_timer && !sleep_q)[*4] |-> $stable(timer_count_q))
    else $error("timer stepped right after a write");

  a_ext_step: assert property (
    @(posedge pclk) disable iff (!presetn)
    (clock_source_select && sync_rise && !sleep_q && inhibit_q == 2'h0 &&
     !wr_timer) |=> timer_count_q == $past(timer_count_q) + 8'h01)
    else $error("external edge did not step the timer");

  a_overflow_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    (timer_inc && timer_count_q == `TC_TMR_MAX)
    |=> overflow_flag_q && timer_count_q == `TC_TMR_RST)
    else $error("wrap did not raise the overflow flag");

  a_flag_sticky: assert property (
    @(posedge pclk) disable iff (!presetn)
    (overflow_flag_q && !wr_intctl) |=> overflow_flag_q)
    else $error("overflow flag dropped without software");

  a_irq_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 timer_irq == $past(overflow_flag_q && overflow_en_q))
    else $error("interrupt output not gated by enable");

  a_sleep_halt: assert property (
    @(posedge pclk) disable iff (!presetn)
    (sleep_q && !wr_timer) |=> timer_count_q == $past(timer_count_q))
    else $error("timer moved during sleep");

  a_presc_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_timer && !prescaler_assign) |=> presc_count == `TC_PRE_RST)
    else $error("timer write left prescaler count");

  a_wd_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_wdclr && prescaler_assign)
    |=> presc_count == `TC_PRE_RST && watchdog_clear)
    else $error("watchdog clear left prescaler count");

  a_apb_ready: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready ##1 !pready)
    else $error("access phase not answered in one cycle");

endmodule // timer_counter_top

//--- verilog/timer_prescaler.sv
`timescale 1ns/1ps
`include "timer_counter_defs.svh"

module timer_prescaler (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      count_en,
  input  wire logic                      clear,
  input  wire timer_counter_pkg::ratio_t ratio_sel,
  output      logic                      out_level,
  output      logic                      wrap,
  output      timer_counter_pkg::count_t count
);

  timer_counter_pkg::count_t cnt_q;
  timer_counter_pkg::count_t cnt_inc;

  // Low ratio_sel+1 bits set, ratio 2^(n+1)
  function automatic timer_counter_pkg::count_t ratio_mask(
    input timer_counter_pkg::ratio_t sel);
    ratio_mask = 8'((9'h002 << sel) - 9'h001);
  endfunction

  assign cnt_inc   = cnt_q + 8'h01;
  assign out_level = cnt_q[sel_idx(ratio_sel)];
  assign wrap      = count_en && ((cnt_inc & ratio_mask(ratio_sel)) == 8'h00);
  assign count     = cnt_q;

  function automatic logic [2:0] sel_idx(input timer_counter_pkg::ratio_t s);
    sel_idx = s;
  endfunction

  // ----------------------------------------------------------------
  // Single shared divider, not in the register map; software writes only clear it
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= `TC_PRE_RST;
    end else if (clear) begin
      cnt_q <= `TC_PRE_RST;
    end else if (count_en) begin
      cnt_q <= cnt_inc;
    end
  end

endmodule // timer_prescaler
